// [rtl/cpfd_pkg.sv]
// Shared constants and carrier types for the compare command engine
package cpfd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CDW10 = 8'h08;
    localparam logic [7:0] OFS_CDW11 = 8'h0C;
    localparam logic [7:0] OFS_CDW12 = 8'h10;
    localparam logic [7:0] OFS_CDW14 = 8'h14;
    localparam logic [7:0] OFS_CDW15 = 8'h18;
    localparam logic [7:0] OFS_META_POINTER_LO = 8'h1C;
    localparam logic [7:0] OFS_META_POINTER_HI = 8'h20;
    localparam logic [7:0] OFS_DPTR0 = 8'h24;
    localparam logic [7:0] OFS_BLKS = 8'h34;
    // Control register fields
    localparam int CTRL_START = 0;
    localparam int CTRL_PI_NS = 1;
    localparam int CTRL_SGL = 2;
    localparam int CTRL_META_LO = 8;
    localparam int CTRL_META_HI = 12;
    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_SCT_LO = 8;
    localparam int ST_SC_LO = 16;
    // Command dword 12 fields
    localparam int D12_PROT_INFO_FIELD_LO = 26;
    localparam int D12_PROT_INFO_FIELD_HI = 29;
    localparam int PROT_INFO_FIELD_ACTION = 3;
    localparam int PROT_INFO_FIELD_GUARD = 2;
    localparam int PROT_INFO_FIELD_APP = 1;
    localparam int PROT_INFO_FIELD_REF = 0;
    // Block layout in 32-bit words
    localparam logic [7:0] DATA_WORDS = 8'h80;
    localparam logic [4:0] PI_WORDS = 5'h02;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Completion status type and codes
    localparam logic [2:0] SCT_GENERIC = 3'h0;
    localparam logic [2:0] SCT_CMD = 3'h1;
    localparam logic [2:0] SCT_MEDIA = 3'h2;
    localparam logic [7:0] SC_SUCCESS = 8'h00;
    localparam logic [7:0] SC_INVALID_PI = 8'h81;
    localparam logic [7:0] SC_CMP_FAIL = 8'h01;
    localparam logic [7:0] SC_PI_CHECK = 8'h02;

    typedef struct packed {
        logic strip;
        logic insert_meta;
        logic pass;
        logic chk_guard;
        logic chk_app;
        logic chk_ref;
        logic invalid;
    } cpfd_pi_ctl_type;

    typedef struct packed {
        logic [2:0] sct;
        logic [7:0] sc;
    } cpfd_cpl_type;

    typedef struct packed {
        logic sgl;
        logic [63:0] meta;
        logic [127:0] data;
    } cpfd_desc_type;
endpackage : cpfd_pkg

// [rtl/cpfd_pi_decode.sv]
// Decoder of the protection action and check field
`timescale 1ns/1ps
`default_nettype none
module cpfd_pi_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] prot_info_field,
    input wire logic pi_ns,
    input wire logic [4:0] meta_words,
    output cpfd_pkg::cpfd_pi_ctl_type pi_ctl
);
    logic act;
    logic meta8;
    // Everything is gated by the namespace format
    assign act = pi_ns && prot_info_field[cpfd_pkg::PROT_INFO_FIELD_ACTION];
    assign meta8 = meta_words == cpfd_pkg::PI_WORDS;
    assign pi_ctl.strip = act && meta8;
    assign pi_ctl.insert_meta = act && (meta_words > cpfd_pkg::PI_WORDS);
    assign pi_ctl.pass = !(act && meta8);
    assign pi_ctl.chk_guard = pi_ns && prot_info_field[cpfd_pkg::PROT_INFO_FIELD_GUARD];
    assign pi_ctl.chk_app = pi_ns && prot_info_field[cpfd_pkg::PROT_INFO_FIELD_APP];
    assign pi_ctl.chk_ref = pi_ns && prot_info_field[cpfd_pkg::PROT_INFO_FIELD_REF];
    // A compare may not ask for an action, so a set action is invalid
    assign pi_ctl.invalid = act;

    property p_strip;
        @(posedge clk) disable iff (rst)
        (pi_ns && prot_info_field[3] && meta_words == 5'h02) |-> pi_ctl.strip && !pi_ctl.pass;
    endproperty
    a_strip: assert property (p_strip) else $error("strip not selected");
    property p_insert;
        @(posedge clk) disable iff (rst)
        (pi_ns && prot_info_field[3] && meta_words > 5'h02) |-> pi_ctl.insert_meta && pi_ctl.pass;
    endproperty
    a_insert: assert property (p_insert) else $error("pass or insert not selected");
    property p_pass;
        @(posedge clk) disable iff (rst)
        !prot_info_field[3] |-> pi_ctl.pass && !pi_ctl.strip && !pi_ctl.insert_meta;
    endproperty
    a_pass: assert property (p_pass) else $error("action clear but not passing");
    property p_ns_off;
        @(posedge clk) disable iff (rst)
        !pi_ns |-> !pi_ctl.chk_guard && !pi_ctl.chk_app && !pi_ctl.chk_ref && !pi_ctl.invalid;
    endproperty
    a_ns_off: assert property (p_ns_off) else $error("fields used without format");
endmodule : cpfd_pi_decode
`default_nettype wire

// [rtl/cpfd_word_cmp.sv]
// Byte-masked comparator of one 32-bit word
`timescale 1ns/1ps
`default_nettype none
module cpfd_word_cmp (
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic [3:0] byte_en,
    output logic miss
);
    logic [3:0] lane_miss;
    // One lane per byte so excluded bytes never count
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign lane_miss[g] = byte_en[g] && (a[8*g+7:8*g] != b[8*g+7:8*g]);
        end
    endgenerate
    assign miss = |lane_miss;
endmodule : cpfd_word_cmp
`default_nettype wire

// [rtl/cpfd_engine.sv]
// Compare command engine with register port, media and host streams
`timescale 1ns/1ps
`default_nettype none
module cpfd_engine (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic media_req_valid,
    input wire logic media_req_ready,
    output logic [63:0] media_req_lba,
    input wire logic media_data_valid,
    input wire logic [31:0] media_data,
    output logic media_data_ready,
    input wire logic host_data_valid,
    input wire logic [31:0] host_data,
    output logic host_data_ready,
    output cpfd_pkg::cpfd_desc_type xfer_desc,
    output logic cpl_valid,
    output cpfd_pkg::cpfd_cpl_type cpl
);
    typedef enum logic [2:0] {S_IDLE, S_CHECK, S_REQ, S_XFER, S_CPL} cpfd_state_type;

    cpfd_state_type state_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] cdw10_reg;
    logic [31:0] cdw11_reg;
    logic [31:0] cdw12_reg;
    logic [31:0] cdw14_reg;
    logic [31:0] cdw15_reg;
    logic [63:0] meta_pointer_reg;
    logic [127:0] buffer_pointer_reg;
    logic done_reg;
    logic miss_reg;
    logic pierr_reg;
    logic [15:0] blk_reg;
    logic [7:0] word_reg;
    logic [31:0] rdata_reg;
    cpfd_pkg::cpfd_pi_ctl_type pi_ctl;
    logic start;
    logic beat;
    logic [4:0] meta_words;
    logic pi_on;
    logic [7:0] last_word;
    logic pi_a;
    logic pi_b;
    logic last_beat;
    logic [3:0] byte_en;
    logic word_miss;
    logic pi_miss;

    // True when a register write hits the given offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = addr == ofs;
    endfunction : hit

    assign meta_words = ctrl_reg[cpfd_pkg::CTRL_META_HI:cpfd_pkg::CTRL_META_LO];
    // Start is ignored while a command is in flight
    assign start = reg_wr && hit(reg_addr, cpfd_pkg::OFS_CTRL)
        && reg_wdata[cpfd_pkg::CTRL_START] && state_reg == S_IDLE;

    cpfd_pi_decode u_pi_decode (
        .clk(clk),
        .rst(rst),
        .prot_info_field(cdw12_reg[cpfd_pkg::D12_PROT_INFO_FIELD_HI:cpfd_pkg::D12_PROT_INFO_FIELD_LO]),
        .pi_ns(ctrl_reg[cpfd_pkg::CTRL_PI_NS]),
        .meta_words(meta_words),
        .pi_ctl(pi_ctl)
    );

    // Command fields; dword 12 bits 25:16 and other dwords are never looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            cdw10_reg <= cpfd_pkg::RST_WORD;
            cdw11_reg <= cpfd_pkg::RST_WORD;
            cdw12_reg <= cpfd_pkg::RST_WORD;
            cdw14_reg <= cpfd_pkg::RST_WORD;
            cdw15_reg <= cpfd_pkg::RST_WORD;
            ctrl_reg <= cpfd_pkg::RST_WORD;
        end else if (reg_wr && state_reg == S_IDLE) begin
            if (hit(reg_addr, cpfd_pkg::OFS_CDW10)) cdw10_reg <= reg_wdata;
            if (hit(reg_addr, cpfd_pkg::OFS_CDW11)) cdw11_reg <= reg_wdata;
            if (hit(reg_addr, cpfd_pkg::OFS_CDW12)) cdw12_reg <= reg_wdata;
            if (hit(reg_addr, cpfd_pkg::OFS_CDW14)) cdw14_reg <= reg_wdata;
            if (hit(reg_addr, cpfd_pkg::OFS_CDW15)) cdw15_reg <= reg_wdata;
            if (hit(reg_addr, cpfd_pkg::OFS_CTRL)) ctrl_reg <= reg_wdata & 32'h0000_1F06;
        end
    end

    // Pointer words, 64 and 128 bits, filled a word at a time
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_pointer_reg <= 64'h0000_0000_0000_0000;
            buffer_pointer_reg <= 128'h0;
        end else if (reg_wr && state_reg == S_IDLE) begin
            if (hit(reg_addr, cpfd_pkg::OFS_META_POINTER_LO)) meta_pointer_reg[31:0] <= reg_wdata;
            if (hit(reg_addr, cpfd_pkg::OFS_META_POINTER_HI)) meta_pointer_reg[63:32] <= reg_wdata;
            for (int i = 0; i < 4; i++) begin
                if (reg_addr == cpfd_pkg::OFS_DPTR0 + 8'(4 * i)) begin
                    buffer_pointer_reg[32*i+:32] <= reg_wdata;
                end
            end
        end
    end

    // Descriptors latched at check time so they stay put during the transfer
    always_ff @(posedge clk) begin
        if (rst) begin
            xfer_desc <= '0;
        end else if (state_reg == S_CHECK) begin
            xfer_desc.sgl <= ctrl_reg[cpfd_pkg::CTRL_SGL];
            xfer_desc.meta <= meta_pointer_reg;
            xfer_desc.data <= buffer_pointer_reg;
        end
    end

    // Block layout: data words, then metadata with protection in the last 8 bytes
    assign pi_on = ctrl_reg[cpfd_pkg::CTRL_PI_NS] && meta_words >= cpfd_pkg::PI_WORDS;
    assign last_word = cpfd_pkg::DATA_WORDS + {3'h0, meta_words} - 8'h01;
    assign pi_a = pi_on && word_reg == last_word - 8'h01;
    assign pi_b = pi_on && word_reg == last_word;
    assign beat = state_reg == S_XFER && media_data_valid && host_data_valid;
    assign last_beat = beat && word_reg == last_word;
    // Handshakes only move both streams together
    assign media_data_ready = beat;
    assign host_data_ready = beat;
    assign byte_en = (pi_a || pi_b) ? 4'h0 : 4'hF;

    cpfd_word_cmp u_word_cmp (
        .a(media_data),
        .b(host_data),
        .byte_en(byte_en),
        .miss(word_miss)
    );

    // Protection field checks against media contents
    always_comb begin
        pi_miss = 1'b0;
        if (pi_a && pi_ctl.chk_guard && media_data[31:16] != host_data[31:16]) begin
            pi_miss = 1'b1;
        end
        if (pi_a && pi_ctl.chk_app && ((media_data[15:0] ^ cdw15_reg[15:0])
            & cdw15_reg[31:16]) != 16'h0000) begin
            pi_miss = 1'b1;
        end
        if (pi_b && pi_ctl.chk_ref && media_data != cdw14_reg + {16'h0000, blk_reg}) begin
            pi_miss = 1'b1;
        end
    end

    // Command sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start) state_reg <= S_CHECK;
                end
                S_CHECK: begin
                    state_reg <= pi_ctl.invalid ? S_CPL : S_REQ;
                end
                S_REQ: begin
                    if (media_req_ready) state_reg <= S_XFER;
                end
                S_XFER: begin
                    if (last_beat) begin
                        // Count is zero based: the block equal to it is the last
                        state_reg <= (blk_reg == cdw12_reg[15:0]) ? S_CPL : S_REQ;
                    end
                end
                S_CPL: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Block and word position
    always_ff @(posedge clk) begin
        if (rst || state_reg == S_CHECK) begin
            blk_reg <= 16'h0000;
            word_reg <= 8'h00;
        end else if (last_beat) begin
            blk_reg <= blk_reg + 16'h0001;
            word_reg <= 8'h00;
        end else if (beat) begin
            word_reg <= word_reg + 8'h01;
        end
    end

    // Contiguous range from the start address
    assign media_req_valid = state_reg == S_REQ;
    assign media_req_lba = {cdw11_reg, cdw10_reg} + {48'h0, blk_reg};

    // Sticky mismatch flags, cleared per command
    always_ff @(posedge clk) begin
        if (rst || state_reg == S_CHECK) begin
            miss_reg <= 1'b0;
            pierr_reg <= 1'b0;
        end else if (beat) begin
            if (word_miss) miss_reg <= 1'b1;
            if (pi_miss) pierr_reg <= 1'b1;
        end
    end

    // Completion entry; protection errors outrank plain miscompares
    always_ff @(posedge clk) begin
        if (rst) begin
            cpl <= '0;
        end else if (state_reg == S_CHECK && pi_ctl.invalid) begin
            cpl <= {cpfd_pkg::SCT_CMD, cpfd_pkg::SC_INVALID_PI};
        end else if (last_beat) begin
            if (pierr_reg || pi_miss) begin
                cpl <= {cpfd_pkg::SCT_MEDIA, cpfd_pkg::SC_PI_CHECK};
            end else if (miss_reg || word_miss) begin
                cpl <= {cpfd_pkg::SCT_MEDIA, cpfd_pkg::SC_CMP_FAIL};
            end else begin
                cpl <= {cpfd_pkg::SCT_GENERIC, cpfd_pkg::SC_SUCCESS};
            end
        end
    end
    assign cpl_valid = state_reg == S_CPL;

    // Done flag: a completion in the same cycle as the clear wins
    always_ff @(posedge clk) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else if (cpl_valid) begin
            done_reg <= 1'b1;
        end else if (reg_wr && hit(reg_addr, cpfd_pkg::OFS_STATUS)
            && reg_wdata[cpfd_pkg::ST_DONE]) begin
            done_reg <= 1'b0;
        end
    end

    // Read port, data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= cpfd_pkg::RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                cpfd_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
                cpfd_pkg::OFS_STATUS: rdata_reg <= {8'h00, cpl.sc, 5'h00, cpl.sct,
                    6'h00, done_reg, state_reg != S_IDLE};
                cpfd_pkg::OFS_CDW10: rdata_reg <= cdw10_reg;
                cpfd_pkg::OFS_CDW11: rdata_reg <= cdw11_reg;
                cpfd_pkg::OFS_CDW12: rdata_reg <= cdw12_reg;
                cpfd_pkg::OFS_CDW14: rdata_reg <= cdw14_reg;
                cpfd_pkg::OFS_CDW15: rdata_reg <= cdw15_reg;
                cpfd_pkg::OFS_BLKS: rdata_reg <= {16'h0000, blk_reg};
                default: rdata_reg <= cpfd_pkg::RST_WORD;
            endcase
        end else begin
            rdata_reg <= cpfd_pkg::RST_WORD;
        end
    end
    assign reg_rdata = rdata_reg;

    property p_invalid_sc;
        @(posedge clk) disable iff (rst)
        (state_reg == S_CHECK && cdw12_reg[29] && ctrl_reg[1])
            |=> cpl_valid && cpl.sc == 8'h81 && cpl.sct == 3'h1;
    endproperty
    a_invalid_sc: assert property (p_invalid_sc) else $error("no 81h for invalid");
    property p_first_lba;
        @(posedge clk) disable iff (rst)
        (state_reg == S_CHECK && !pi_ctl.invalid)
            |=> media_req_valid && media_req_lba == {cdw11_reg, cdw10_reg};
    endproperty
    a_first_lba: assert property (p_first_lba) else $error("bad first block");
    property p_last_block;
        @(posedge clk) disable iff (rst)
        (last_beat && blk_reg == cdw12_reg[15:0]) |=> cpl_valid ##1 state_reg == S_IDLE;
    endproperty
    a_last_block: assert property (p_last_block) else $error("count not honoured");
    property p_next_block;
        @(posedge clk) disable iff (rst)
        (last_beat && blk_reg != cdw12_reg[15:0])
            |=> media_req_valid && media_req_lba == $past(media_req_lba) + 64'h1;
    endproperty
    a_next_block: assert property (p_next_block) else $error("range not contiguous");
    property p_fail;
        @(posedge clk) disable iff (rst)
        (cpl_valid && miss_reg && !pierr_reg && !$past(pi_ctl.invalid))
            |-> cpl.sc == 8'h01 && cpl.sct == 3'h2;
    endproperty
    a_fail: assert property (p_fail) else $error("miscompare not failed");
    property p_success;
        @(posedge clk) disable iff (rst)
        (cpl_valid && !miss_reg && !pierr_reg && $past(state_reg) == S_XFER)
            |-> cpl.sc == 8'h00;
    endproperty
    a_success: assert property (p_success) else $error("clean compare not success");
    property p_pi_excluded;
        @(posedge clk) disable iff (rst)
        (beat && (pi_a || pi_b)) |-> !word_miss;
    endproperty
    a_pi_excluded: assert property (p_pi_excluded) else $error("protection bytes compared");
    property p_no_checks;
        @(posedge clk) disable iff (rst)
        (state_reg == S_XFER && !pi_ctl.chk_guard && !pi_ctl.chk_app && !pi_ctl.chk_ref)
            |=> !$rose(pierr_reg);
    endproperty
    a_no_checks: assert property (p_no_checks) else $error("unrequested check");
    property p_desc;
        @(posedge clk) disable iff (rst)
        (state_reg == S_CHECK) |=> xfer_desc.meta == meta_pointer_reg && xfer_desc.data == buffer_pointer_reg
            && xfer_desc.sgl == ctrl_reg[2];
    endproperty
    a_desc: assert property (p_desc) else $error("descriptors not taken");
endmodule : cpfd_engine
`default_nettype wire

// [testbench/cpfd_media_model.sv]
// Media side model: takes one block request and streams that block
`timescale 1ns/1ps
`default_nettype none
module cpfd_media_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [4:0] meta_words,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [63:0] req_lba,
    output logic data_valid,
    output logic [31:0] data,
    input wire logic data_ready
);
    logic active;
    logic tick;
    logic [7:0] idx;
    logic [63:0] lba;
    logic [31:0] last;
    logic [63:0] lba_log[$];
    // Word pattern; the last two metadata words carry guard/app and ref
    function automatic logic [31:0] word(input logic [63:0] l, input logic [7:0] i,
                                         input logic [4:0] mw);
        if (mw >= 5'h02 && i == 8'h7E + 8'(mw)) return 32'hA5A5_1234;
        if (mw >= 5'h02 && i == 8'h7F + 8'(mw)) return l[31:0];
        return {l[15:0], 8'h5A, i};
    endfunction : word
    // Slow mode answers only every other cycle, like a busy medium
    assign req_ready = req_valid && !active && (!slow || tick);
    assign data_valid = active && (!slow || tick);
    // Idle line shows the inverse of the last word, never a stale copy
    assign data = data_valid ? word(lba, idx, meta_words) : ~last;
    // Request acceptance and block streaming
    always_ff @(posedge clk) begin
        if (rst) begin
            active <= 1'h0;
            tick <= 1'h0;
            idx <= 8'h00;
            last <= 32'h0;
        end else begin
            tick <= ~tick;
            if (req_ready) begin
                active <= 1'h1;
                idx <= 8'h00;
                lba <= req_lba;
            end else if (data_valid && data_ready) begin
                last <= data;
                idx <= idx + 8'h01;
                if (idx == 8'h7F + 8'(meta_words)) active <= 1'h0;
            end
        end
    end
    // Request log kept in a plain process, since the bench empties it between commands
    always @(posedge clk) begin
        if (!rst && req_ready) lba_log.push_back(req_lba);
    end
endmodule : cpfd_media_model
`default_nettype wire

// [testbench/compare_pi_field_decode_tb_top.sv]
// Self-checking bench for the compare command engine
`timescale 1ns/1ps
`default_nettype none
module compare_pi_field_decode_tb_top;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata, mdat, host_data;
    logic mreq_valid, mreq_ready, mdat_valid, mdat_ready, host_data_valid, host_data_ready;
    logic cpl_valid;
    logic [63:0] mreq_lba;
    cpfd_pkg::cpfd_desc_type xfer_desc;
    cpfd_pkg::cpfd_cpl_type cpl;
    logic slow = 1'h0;
    logic [4:0] mw = 5'h00;
    logic [1:0] cyc = 2'h0;
    logic [7:0] h_idx = 8'h00;
    logic [63:0] h_lba = 64'h0;
    logic [15:0] h_g = 16'h0000;
    logic [15:0] bad = 16'hFFFF;
    logic [31:0] flip = 32'h0;
    logic [127:0] buffer_pointer = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    int n_fail = 0;
    int total_checks = 0;
    int i;
    int k;
    int c;
    cpfd_engine uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .media_req_valid(mreq_valid),
        .media_req_ready(mreq_ready), .media_req_lba(mreq_lba), .media_data_valid(mdat_valid),
        .media_data(mdat), .media_data_ready(mdat_ready), .host_data_valid(host_data_valid),
        .host_data(host_data), .host_data_ready(host_data_ready), .xfer_desc(xfer_desc),
        .cpl_valid(cpl_valid), .cpl(cpl));
    cpfd_media_model u_media (.clk(clk), .rst(rst), .slow(slow), .meta_words(mw),
        .req_valid(mreq_valid), .req_ready(mreq_ready), .req_lba(mreq_lba),
        .data_valid(mdat_valid), .data(mdat), .data_ready(mdat_ready));
    // Host buffer repeats the media pattern; one word may be spoiled on purpose
    assign host_data = u_media.word(h_lba, h_idx, mw) ^ ((h_g == bad) ? flip : 32'h0);
    assign host_data_valid = !slow || cyc[1];
    initial begin
        forever #20 clk = ~clk;
    end
    // Host stream advances only on accepted beats
    always @(posedge clk) begin
        cyc <= cyc + 2'h1;
        if (host_data_ready) begin
            h_g <= h_g + 16'h0001;
            h_idx <= (h_idx == 8'h7F + 8'(mw)) ? 8'h00 : h_idx + 8'h01;
            if (h_idx == 8'h7F + 8'(mw)) h_lba <= h_lba + 64'h1;
        end
    end
    task automatic chk(input logic [192:0] got, input logic [192:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask : wr
    // Read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk(193'(reg_rdata), 193'(exp));
    endtask : rd
    function automatic logic [31:0] d12(input logic [3:0] pf, input logic [15:0] block_count_zero_based);
        return {2'h0, pf, 10'h000, block_count_zero_based};
    endfunction : d12
    // Loads a command, starts it, and checks completion and block requests
    task automatic run_cmd(input logic [63:0] start_block_addr, input logic [31:0] w12, w14, w15,
                           input logic sgl, pi, input logic [10:0] exp, input int nreq);
        int n;
        h_idx <= 8'h00;
        h_lba <= start_block_addr;
        h_g <= 16'h0000;
        u_media.lba_log.delete();
        wr(cpfd_pkg::OFS_CDW10, start_block_addr[31:0]);
        wr(cpfd_pkg::OFS_CDW11, start_block_addr[63:32]);
        wr(cpfd_pkg::OFS_CDW12, w12);
        wr(cpfd_pkg::OFS_CDW14, w14);
        wr(cpfd_pkg::OFS_CDW15, w15);
        wr(cpfd_pkg::OFS_CTRL, {19'h0, mw, 5'h00, sgl, pi, 1'h1});
        n = 0;
        while (cpl_valid !== 1'h1 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4000) begin
            n_fail++;
            $display("[FAIL] %0t no completion", $time);
            wrap_up();
        end else begin
            chk(193'(cpl), 193'(exp));
            chk(193'(u_media.lba_log.size()), 193'(nreq));
            for (n = 0; n < u_media.lba_log.size(); n++)
                chk(193'(u_media.lba_log[n]), 193'(start_block_addr + 64'(n)));
        end
    endtask : run_cmd
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rd(cpfd_pkg::OFS_CTRL, cpfd_pkg::RST_WORD);
        rd(cpfd_pkg::OFS_STATUS, cpfd_pkg::RST_WORD);
        rd(cpfd_pkg::OFS_BLKS, cpfd_pkg::RST_WORD);
        rd(8'hFC, 32'h0);
        wr(cpfd_pkg::OFS_META_POINTER_LO, 32'h89AB_CDEF);
        wr(cpfd_pkg::OFS_META_POINTER_HI, 32'h0123_4567);
        rd(cpfd_pkg::OFS_META_POINTER_LO, 32'h0);
        for (i = 0; i < 4; i++) wr(cpfd_pkg::OFS_DPTR0 + 8'(i * 4), buffer_pointer[i*32+:32]);
        // Two blocks across a 32-bit carry of the start address
        run_cmd(64'h0000_0001_FFFF_FFFF, d12(4'h0, 16'h0001), 32'h0, 32'h0, 1'h0, 1'h0,
                {cpfd_pkg::SCT_GENERIC, cpfd_pkg::SC_SUCCESS}, 2);
        chk(193'(xfer_desc), {1'h0, 64'h0123_4567_89AB_CDEF, buffer_pointer});
        rd(cpfd_pkg::OFS_BLKS, 32'h2);
        rd(cpfd_pkg::OFS_STATUS, 32'h2);
        wr(cpfd_pkg::OFS_STATUS, 32'h2);
        rd(cpfd_pkg::OFS_STATUS, 32'h0);
        // Stalling media, one bad word in the last block, list mode
        slow = 1'h1;
        bad = 16'h0105;
        flip = 32'h0000_0100;
        run_cmd(64'h40, d12(4'h0, 16'h0002), 32'h0, 32'h0, 1'h1, 1'h0,
                {cpfd_pkg::SCT_MEDIA, cpfd_pkg::SC_CMP_FAIL}, 3);
        chk(193'(xfer_desc.sgl), 193'(1));
        slow = 1'h0;
        // Plain metadata is compared, protection words are not
        mw = 5'h04;
        flip = 32'h1;
        bad = 16'h0080;
        run_cmd(64'h20, d12(4'h0, 16'h0000), 32'h0, 32'h0, 1'h0, 1'h1,
                {cpfd_pkg::SCT_MEDIA, cpfd_pkg::SC_CMP_FAIL}, 1);
        bad = 16'h0083;
        run_cmd(64'h20, d12(4'h0, 16'h0000), 32'h0, 32'h0, 1'h0, 1'h1,
                {cpfd_pkg::SCT_GENERIC, cpfd_pkg::SC_SUCCESS}, 1);
        // Each check bit catches its own spoiled field, which passes when no check bit is set
        mw = 5'h02;
        flip = 32'h0001_0000;
        for (k = 0; k < 3; k++) begin
            for (c = 0; c < 2; c++) begin
                bad = (k == 2) ? 16'h0080 : 16'hFFFF;
                run_cmd(64'h77, d12(4'(c << k), 16'h0000), (k == 0) ? 32'h78 : 32'h77,
                        (k == 1) ? 32'hFFFF_1235 : 32'hFFFF_1234, 1'h0, 1'h1,
                        c ? {cpfd_pkg::SCT_MEDIA, cpfd_pkg::SC_PI_CHECK}
                          : {cpfd_pkg::SCT_GENERIC, cpfd_pkg::SC_SUCCESS}, 1);
            end
        end
        bad = 16'hFFFF;
        run_cmd(64'h10, d12(4'h8, 16'h0000), 32'h0, 32'h0, 1'h0, 1'h1,
                {cpfd_pkg::SCT_CMD, cpfd_pkg::SC_INVALID_PI}, 0);
        // Without protection the field is ignored, even with wrong tags
        run_cmd(64'h10, d12(4'hF, 16'h0000), 32'h0, 32'hFFFF_0000, 1'h0, 1'h0,
                {cpfd_pkg::SCT_GENERIC, cpfd_pkg::SC_SUCCESS}, 1);
        wrap_up();
    end
endmodule : compare_pi_field_decode_tb_top
`default_nettype wire
